// ---- tx_pkg.sv ----
/*
  Constants and types shared by the asynchronous serial transmitter.
  Assumes a single 250 MHz system clock and an active-low async reset.
*/
`default_nettype none

package tx_pkg;

  // Clock and instruction cycle
  localparam int CLK_PERIOD_NS = 4;
  localparam int TCY_NS = 16;
  localparam int TCY_CYCLES = (TCY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Character format
  localparam int CHAR_W = 8;
  localparam int WORD_W = CHAR_W + 1;
  localparam int FIFO_DEPTH = 8;
  localparam logic [3:0] LAST_BIT_8 = 4'h7;
  localparam logic [3:0] LAST_BIT_9 = 4'h8;
  localparam logic [3:0] BIT_IDX_RST = 4'h0;

  // Baud generator prescale, in system clocks per divisor step
  localparam logic [4:0] PRESC_LOW_SPEED = 5'h10;
  localparam logic [4:0] PRESC_HIGH_SPEED = 5'h04;
  localparam logic [15:0] DIV_RST = 16'h0000;
  localparam logic [4:0] PRESC_RST = 5'h00;

  // Line levels before polarity
  localparam logic LINE_MARK = 1'b1;
  localparam logic LINE_SPACE = 1'b0;

  // Values after reset; the buffer-empty flag itself resets to 0, not FLAG_RST
  localparam logic [WORD_W-1:0] WORD_RST = 9'h000;
  localparam logic FLAG_RST = 1'b1;
  localparam logic EMPTY_RST = 1'b1;
  localparam logic OE_N_RST = 1'b1;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_START = 2'b01,
    ST_DATA = 2'b10,
    ST_STOP = 2'b11
  } tx_state_t;

endpackage

`default_nettype wire

// ---- async_serial_transmitter.sv ----
/*
  Character FIFO and asynchronous NRZ transmitter with holding register,
  shift register and baud generator.
  Assumes all control inputs come from register logic on sys_clk; the
  serial line leaves through a driver enabled by tx_out_oe_n low.
*/
`timescale 1ns/1ps
`default_nettype none

module char_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 8
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic clear,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW:0] DEPTH_C = (AW + 1)'(DEPTH);
  localparam logic [AW-1:0] LAST_C = AW'(DEPTH - 1);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [AW:0] count_q;
  logic [AW:0] count_d;
  logic push;
  logic pop;

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == LAST_C) ? '0 : p + 1'b1;
  endfunction

  // Ready is a flop so the top-level write handshake is registered
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  assign out_valid = (count_q != '0);
  assign out_data = mem_q[rd_ptr_q];

  always_comb begin
    count_d = count_q;
    if (push && !pop) begin
      count_d = count_q + 1'b1;
    end else if (pop && !push) begin
      count_d = count_q - 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_ptr_q] <= in_data;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b1;
    end else if (clear) begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
      in_ready <= 1'b1;
    end else begin
      if (push) begin
        wr_ptr_q <= bump(wr_ptr_q);
      end
      if (pop) begin
        rd_ptr_q <= bump(rd_ptr_q);
      end
      count_q <= count_d;
      in_ready <= (count_d != DEPTH_C);
    end
  end
endmodule

// What this block does
// - Idle mark, space start, data, mark stop
// - Data bits leave least significant first
// - Every bit lasts exactly one bit period
// - Bit timing from shared 8/16-bit divisor
// - No parity; ninth bit carries software parity
// - Runs only when enabled, async, port on
// - Write starts transfer; empty shifter loads immediately
// - Queued character loads right after stop bit
// - Polarity select inverts idle level and data
// - Buffer-empty flag set while running unless character queued
// - Flag correct by second instruction cycle
// - Flag read-only; enable gates only interrupt
// - Shifter-empty status clears on load, sets after
// - Nine-bit mode sends ninth bit last
module async_serial_transmitter
  import tx_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic tx_enable_bit,
  input wire logic sync_mode_bit,
  input wire logic port_enable_bit,
  input wire logic polarity_select,
  input wire logic nine_bit_tx_enable,
  input wire logic tx_ninth_bit,
  input wire logic tx_irq_enable,
  input wire logic brg16_select,
  input wire logic high_speed_select,
  input wire logic [15:0] baud_divisor,
  input wire logic tx_hold_write,
  input wire logic [CHAR_W-1:0] tx_hold_data,
  output logic tx_hold_ready,
  output logic tx_out,
  output logic tx_out_oe_n,
  output logic tx_buffer_empty_flag,
  output logic shifter_empty_status,
  output logic tx_irq
);
  tx_state_t state_q;
  logic tx_active;
  logic fifo_valid;
  logic fifo_rd;
  logic [WORD_W-1:0] fifo_word;
  logic [WORD_W-1:0] hold_q;
  logic hold_valid_q;
  logic [WORD_W-1:0] shift_q;
  logic [3:0] bit_idx_q;
  logic [4:0] presc_q;
  logic [15:0] div_q;
  logic step;
  logic bit_tick;
  logic load_sh;
  logic [3:0] last_bit;

  // Line level for a logical bit under the selected polarity
  function automatic logic line_level(input logic b, input logic inv);
    line_level = b ^ inv;
  endfunction

  assign tx_active = tx_enable_bit && !sync_mode_bit && port_enable_bit;
  assign last_bit = nine_bit_tx_enable ? LAST_BIT_9 : LAST_BIT_8;

  // Ninth bit is taken at write time with the low byte
  char_fifo #(
    .WIDTH(WORD_W),
    .DEPTH(DEPTH)
  ) u_fifo (
    .sys_clk(sys_clk),
    .rstn(rstn),
    .clear(!port_enable_bit),
    .in_valid(tx_hold_write),
    .in_ready(tx_hold_ready),
    .in_data({tx_ninth_bit, tx_hold_data}),
    .out_valid(fifo_valid),
    .out_ready(fifo_rd),
    .out_data(fifo_word)
  );

  assign fifo_rd = !hold_valid_q && port_enable_bit;

  // Holding register, one character
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      hold_q <= WORD_RST;
      hold_valid_q <= 1'b0;
    end else if (!port_enable_bit) begin
      hold_valid_q <= 1'b0;
    end else if (fifo_rd && fifo_valid) begin
      hold_q <= fifo_word;
      hold_valid_q <= 1'b1;
    end else if (load_sh) begin
      hold_valid_q <= 1'b0;
    end
  end

  // Baud generator: prescale steps, then divisor, restarted at load
  assign step = (presc_q == ((high_speed_select ? PRESC_HIGH_SPEED
                : PRESC_LOW_SPEED) - 5'h01));
  assign bit_tick = step && (div_q == (brg16_select ? baud_divisor
                    : {8'h00, baud_divisor[7:0]}));

  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      presc_q <= PRESC_RST;
      div_q <= DIV_RST;
    end else if (load_sh || state_q == ST_IDLE) begin
      presc_q <= PRESC_RST;
      div_q <= DIV_RST;
    end else if (bit_tick) begin
      presc_q <= PRESC_RST;
      div_q <= DIV_RST;
    end else if (step) begin
      presc_q <= PRESC_RST;
      div_q <= div_q + 16'h0001;
    end else begin
      presc_q <= presc_q + 5'h01;
    end
  end

  // Load when idle, or on the tick that ends a stop bit
  assign load_sh = hold_valid_q && tx_active
                   && (state_q == ST_IDLE
                   || (state_q == ST_STOP && bit_tick));

  // Shift register, bit sequencing and line level
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= ST_IDLE;
      shift_q <= WORD_RST;
      bit_idx_q <= BIT_IDX_RST;
      tx_out <= LINE_MARK;
      shifter_empty_status <= EMPTY_RST;
    end else if (!tx_active) begin
      state_q <= ST_IDLE;
      bit_idx_q <= BIT_IDX_RST;
      tx_out <= line_level(LINE_MARK, polarity_select);
      shifter_empty_status <= 1'b1;
    end else if (load_sh) begin
      state_q <= ST_START;
      shift_q <= hold_q;
      bit_idx_q <= BIT_IDX_RST;
      tx_out <= line_level(LINE_SPACE, polarity_select);
      shifter_empty_status <= 1'b0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          tx_out <= line_level(LINE_MARK, polarity_select);
          shifter_empty_status <= 1'b1;
        end
        ST_START: begin
          if (bit_tick) begin
            state_q <= ST_DATA;
            tx_out <= line_level(shift_q[0], polarity_select);
          end
        end
        ST_DATA: begin
          if (bit_tick) begin
            shift_q <= {1'b0, shift_q[WORD_W-1:1]};
            bit_idx_q <= bit_idx_q + 4'h1;
            if (bit_idx_q == last_bit) begin
              state_q <= ST_STOP;
              tx_out <= line_level(LINE_MARK, polarity_select);
            end else begin
              tx_out <= line_level(shift_q[1], polarity_select);
            end
          end
        end
        ST_STOP: begin
          if (bit_tick) begin
            state_q <= ST_IDLE;
            shifter_empty_status <= 1'b1;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  // Status flags and driver enable
  always_ff @(posedge sys_clk or negedge rstn) begin
    if (!rstn) begin
      tx_buffer_empty_flag <= 1'b0;
      tx_irq <= 1'b0;
      tx_out_oe_n <= OE_N_RST;
    end else begin
      tx_buffer_empty_flag <= tx_active && !hold_valid_q
                              && !fifo_valid;
      tx_irq <= tx_irq_enable && tx_active && !hold_valid_q
                && !fifo_valid;
      tx_out_oe_n <= !port_enable_bit;
    end
  end

  AST_IDLE_MARK: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == ST_IDLE && $past(state_q) == ST_IDLE && !load_sh)
    |=> tx_out == ($past(polarity_select) ^ LINE_MARK))
    else $error("idle line not at mark level");

  AST_START_SPACE: assert property (@(posedge sys_clk) disable iff (!rstn)
    load_sh |=> (tx_out == ($past(polarity_select) ^ LINE_SPACE))
    && state_q == ST_START)
    else $error("start bit not at space level");

  AST_BIT_HOLD: assert property (@(posedge sys_clk) disable iff (!rstn)
    ($changed(tx_out) && $past(state_q) != ST_IDLE)
    |-> $past(bit_tick || load_sh || !tx_active))
    else $error("line changed inside a bit period");

  AST_LSB_FIRST: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == ST_START && bit_tick && tx_active && !load_sh)
    |=> tx_out == ($past(shift_q[0]) ^ $past(polarity_select)))
    else $error("first data bit is not bit zero");

  AST_FLAG_EMPTY: assert property (@(posedge sys_clk) disable iff (!rstn)
    (tx_active && !hold_valid_q && !fifo_valid) [*2]
    |-> tx_buffer_empty_flag)
    else $error("buffer empty flag not set");

  AST_FLAG_WRITE: assert property (@(posedge sys_clk) disable iff (!rstn)
    (tx_hold_write && tx_hold_ready && port_enable_bit)
    |-> ##2 !tx_buffer_empty_flag)
    else $error("buffer empty flag not cleared after write");

  AST_SHIFTER_EMPTY_STATUS_LOAD: assert property (@(posedge sys_clk) disable iff (!rstn)
    load_sh |=> !shifter_empty_status ##1 !shifter_empty_status)
    else $error("shifter empty status set after load");

  AST_STOP_NEXT: assert property (@(posedge sys_clk) disable iff (!rstn)
    (state_q == ST_STOP && bit_tick && hold_valid_q && tx_active)
    |=> state_q == ST_START && !tx_out_oe_n)
    else $error("queued character not loaded after stop");

  AST_DISABLED: assert property (@(posedge sys_clk) disable iff (!rstn)
    !port_enable_bit |=> state_q == ST_IDLE && shifter_empty_status
    && tx_out_oe_n && !hold_valid_q)
    else $error("disabled port not reset");

  COV_FRAME: cover property (@(posedge sys_clk) disable iff (!rstn)
    load_sh ##1 state_q == ST_START);
  COV_BACK_TO_BACK: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_STOP && bit_tick && load_sh);
  COV_NINE_BIT: cover property (@(posedge sys_clk) disable iff (!rstn)
    state_q == ST_DATA && bit_tick && bit_idx_q == LAST_BIT_9);
  COV_FULL: cover property (@(posedge sys_clk) disable iff (!rstn)
    !tx_hold_ready && tx_hold_write);

endmodule

`default_nettype wire

// ---- serial_rx_model.sv ----
/*
  Receiver model for the transmit line: hunts a start bit, samples mid-bit.
  Assumes the bench gives bit period in clocks, polarity and word size.
*/
`timescale 1ns/1ps
`default_nettype none

module serial_rx_model (
  input wire logic sys_clk,
  input wire logic line,
  input wire logic inv,
  input wire logic nine,
  input wire logic [15:0] bit_period,
  output logic [8:0] rx_word,
  output logic rx_valid,
  output logic rx_bad
);
  int n;
  initial begin
    rx_valid = 1'b0;
    rx_bad = 1'b0;
    rx_word = 9'h000;
    forever begin
      @(posedge sys_clk);
      rx_valid <= 1'b0;
      if ((line ^ inv) == 1'b0) begin
        repeat (bit_period / 2) @(posedge sys_clk);
        // Glitch, not a start bit
        if ((line ^ inv) != 1'b0) continue;
        for (n = 0; n < (nine ? 9 : 8); n++) begin
          repeat (bit_period) @(posedge sys_clk);
          rx_word[n] <= line ^ inv;
        end
        for (n = n; n < 9; n++) rx_word[n] <= 1'b0;
        repeat (bit_period) @(posedge sys_clk);
        rx_bad <= (line ^ inv) != 1'b1;
        rx_valid <= 1'b1;
      end
    end
  end
endmodule

`default_nettype wire

// ---- async_serial_transmitter_bench.sv ----
/*
  Self-checking bench: random characters, receiver model, status checks.
  Assumes the transmitter and tx_pkg are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module async_serial_transmitter_bench;
  import tx_pkg::*;
  logic sys_clk, rstn, tx_enable_bit, sync_mode_bit, port_enable_bit;
  logic polarity_select, nine_bit_tx_enable, tx_ninth_bit, tx_irq_enable;
  logic brg16_select, high_speed_select, tx_hold_write, skip;
  logic [15:0] baud_divisor, per;
  logic [CHAR_W-1:0] tx_hold_data;
  logic tx_hold_ready, tx_out, tx_out_oe_n, tx_buffer_empty_flag;
  logic shifter_empty_status, tx_irq, rx_valid, rx_bad;
  logic [8:0] rx_word, w, e;
  logic [8:0] exp_q[$];
  int num_errors, n_tests, seed, cyc, i, k;

  async_serial_transmitter dut_u (.sys_clk, .rstn, .tx_enable_bit,
    .sync_mode_bit, .port_enable_bit, .polarity_select, .nine_bit_tx_enable,
    .tx_ninth_bit, .tx_irq_enable, .brg16_select, .high_speed_select,
    .baud_divisor, .tx_hold_write, .tx_hold_data, .tx_hold_ready, .tx_out,
    .tx_out_oe_n, .tx_buffer_empty_flag, .shifter_empty_status, .tx_irq);
  serial_rx_model rx_u (.sys_clk, .line(tx_out), .inv(polarity_select),
    .nine(nine_bit_tx_enable), .bit_period(per), .rx_word, .rx_valid,
    .rx_bad);

  task automatic cmp_w(input logic [8:0] got, input logic [8:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmp_b(input logic got, input logic exp);
    cmp_w({8'h00, got}, {8'h00, exp});
  endtask

  task automatic test_done;
    $display("errors=%0d checks=%0d", num_errors, n_tests);
    if (num_errors == 0 && n_tests > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic idle_chk(input logic fl);
    cmp_b(tx_out, LINE_MARK ^ polarity_select);
    cmp_b(shifter_empty_status, 1'b1);
    cmp_b(tx_buffer_empty_flag, fl);
    cmp_b(tx_irq, fl & tx_irq_enable);
    cmp_b(tx_hold_ready, 1'b1);
  endtask

  // Writes held until accepted; ninth bit goes with the byte
  task automatic put(input int cnt);
    for (k = 0; k < cnt; k++) begin
      w = 9'($random(seed));
      tx_ninth_bit <= w[8];
      tx_hold_data <= w[7:0];
      if (k == cnt - 1) tx_irq_enable <= 1'b0;
      tx_hold_write <= 1'b1;
      @(posedge sys_clk);
      while (tx_hold_ready !== 1'b1) @(posedge sys_clk);
      exp_q.push_back(nine_bit_tx_enable ? w : {1'b0, w[7:0]});
    end
    tx_hold_write <= 1'b0;
  endtask

  task automatic run(input logic p, n9, b, h, input logic [15:0] d, bp,
    input int cnt);
    @(posedge sys_clk);
    polarity_select <= p;
    nine_bit_tx_enable <= n9;
    brg16_select <= b;
    high_speed_select <= h;
    baud_divisor <= d;
    tx_irq_enable <= 1'($random(seed));
    per <= bp;
    repeat (4) @(posedge sys_clk);
    idle_chk(1'b1);
    put(cnt);
    repeat (8) @(posedge sys_clk);
    cmp_b(tx_buffer_empty_flag, 1'b0);
    cmp_b(shifter_empty_status, 1'b0);
    cmp_b(tx_hold_ready, cnt < FIFO_DEPTH + 2);
    for (i = 0; i < 60000 && exp_q.size() > 0; i++) @(posedge sys_clk);
    repeat (per) @(posedge sys_clk);
    idle_chk(1'b1);
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc > 80000) begin
      num_errors++;
      test_done;
    end
    if (rx_valid && !skip) begin
      e = exp_q.size() > 0 ? exp_q.pop_front() : 9'hXXX;
      cmp_w(rx_word, e);
      cmp_b(rx_bad, 1'b0);
    end
  end

  initial begin
    seed = 96;
    {rstn, sync_mode_bit, tx_ninth_bit, tx_hold_write, skip} = '0;
    {polarity_select, nine_bit_tx_enable, tx_irq_enable} = '0;
    {brg16_select, tx_hold_data} = '0;
    {tx_enable_bit, port_enable_bit, high_speed_select} = 3'h7;
    baud_divisor = 16'h0102;
    per = 16'h000C;
    repeat (10) @(posedge sys_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge sys_clk);
    idle_chk(1'b1);
    cmp_b(tx_out_oe_n, 1'b0);
    // Bit period = (N+1) x prescale clocks
    run(1'b0, 1'b0, 1'b0, 1'b1, 16'h0102, 16'h000C, 12);
    run(1'b1, 1'b1, 1'b1, 1'b1, 16'h0100, 16'h0404, 2);
    run(1'b0, 1'b1, 1'b0, 1'b0, 16'h0000, 16'h0010, 12);
    run(1'b1, 1'b0, 1'b0, 1'b0, 16'h0001, 16'h0020, 12);
    // Port off in mid frame
    put(3);
    repeat (40) @(posedge sys_clk);
    skip <= 1'b1;
    port_enable_bit <= 1'b0;
    repeat (3) @(posedge sys_clk);
    idle_chk(1'b0);
    cmp_b(tx_out_oe_n, 1'b1);
    exp_q.delete();
    repeat (400) @(posedge sys_clk);
    port_enable_bit <= 1'b1;
    skip <= 1'b0;
    repeat (4) @(posedge sys_clk);
    cmp_b(tx_out_oe_n, 1'b0);
    run(1'b0, 1'b0, 1'b0, 1'b1, 16'h0102, 16'h000C, 3);
    tx_enable_bit <= 1'b0;
    repeat (4) @(posedge sys_clk);
    idle_chk(1'b0);
    tx_enable_bit <= 1'b1;
    sync_mode_bit <= 1'b1;
    repeat (4) @(posedge sys_clk);
    idle_chk(1'b0);
    sync_mode_bit <= 1'b0;
    repeat (4) @(posedge sys_clk);
    idle_chk(1'b1);
    test_done;
  end
endmodule

`default_nettype wire
